//--- hw/siss_pkg.sv
/*
 * Shared constants and carriers for the serial input state shifter.
 * Assumes a single 100 MHz core clock; all pins arrive asynchronously.
 */
package siss_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CORE_CLK_MHZ = 100;
    localparam int UV_FILT_TIME_US = 1000;
    // least time: exact at whole MHz, so no rounding is lost
    localparam int UV_FILT_CYC = UV_FILT_TIME_US * CORE_CLK_MHZ;
    localparam int UV_CNT_W = 17;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_W = 16;
    localparam logic [4:0] LONG_BITS = 5'h10;
    localparam logic [4:0] SHORT_BITS = 5'h08;
    localparam int POS_UVA = 7;
    localparam int POS_OTA = 6;
    localparam int POS_PAR_FULL = 5;
    localparam int POS_PAR_UPPER = 4;
    localparam int POS_PAR_LOWER = 3;
    localparam int POS_PAR_MIDDLE = 2;
    localparam int POS_STOP_LOW = 1;
    localparam int POS_STOP_HIGH = 0;
    localparam logic STOP_LOW_VAL = 1'b0;
    localparam logic STOP_HIGH_VAL = 1'b1;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
        logic frame_length_select;
        logic bus_supply_sense;
        logic overtemp_alarm;
        logic bus_power_present;
        logic power_reset_n;
        logic [7:0] input_state;
    } siss_pins_t;

    localparam int PINS_W = 16;
    // idle pins: chip select high, everything else low
    localparam logic [15:0] PIN_RST = 16'h8000;

    typedef struct packed {
        logic [PINS_W-1:0] s1;
        logic [PINS_W-1:0] s2;
        logic [PINS_W-1:0] s3;
        logic [PINS_W-1:0] f;
        logic [FRAME_W-1:0] shift;
        logic [4:0] nbits;
        logic long_mode;
        logic mosi_cap;
        logic [UV_CNT_W-1:0] uv_cnt;
        logic uva_n;
        logic miso;
        logic miso_oe;
        logic [FRAME_W-1:0] buf0;
        logic [FRAME_W-1:0] buf1;
        logic v0;
        logic v1;
    } siss_state_t;

endpackage

//--- hw/siss_shifter.sv
/*
 * Slave-side SPI serializer for eight filtered input states plus status.
 * Assumes the SPI master, the input filter and the supply comparators sit
 * outside; all pins are asynchronous and sampled on core_clk.
 */
// How it works
// - long mode takes 16 bits or more within one chip-select low window, one bit per falling clock edge
// - long frame sends inputs first, then alarms and parities, then stop bits
// - input 8 is bit 15, input 1 is bit 8, others in order
// - select high sends only the eight inputs, input 8 first
// - active-low undervoltage alarm sits in control bit 7
// - undervoltage alarm low while bus supply low; transfer keeps running
// - supply drop-outs shorter than one millisecond never raise the alarm
// - active-low overtemperature alarm sits in control bit 6
// - overtemperature alarm low while hot; operation continues
// - parities: middle bit 2, lower bit 3, upper bit 4, full bit 5
// - full-byte parity is XNOR of all eight inputs
// - nibble parities are XNOR of inputs 5-8, 1-4 and 3-6
// - bit 0 is a high stop bit, bit 1 a low stop bit
// - bus power lost: sleep, data output held low during transfers
// - power-loss reset asserted: sleep, serial output enabled but held low during transfers
// - chip-select fall loads inputs and control bits in parallel
// - first bit at chip-select fall, next bits on falling clock edges
// - chip select high: clock and data ignored, output released
`timescale 1ns/10ps

module siss_shifter #(
    parameter int UV_FILT_CYCLES = siss_pkg::UV_FILT_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic frame_length_select,
    input wire logic bus_supply_sense,
    input wire logic overtemp_alarm,
    input wire logic bus_power_present,
    input wire logic power_reset_n,
    input wire logic [7:0] input_state,
    input wire logic rx_ready,
    output logic miso,
    output logic miso_oe,
    output logic undervoltage_alarm_n,
    output logic [siss_pkg::FRAME_W-1:0] rx_word,
    output logic rx_valid,
    output logic rx_full
);
    import siss_pkg::*;

    // ****************************************
    // state
    // ****************************************
    localparam logic [UV_CNT_W-1:0] UV_LAST = UV_CNT_W'(UV_FILT_CYCLES - 1);

    siss_state_t q_q;
    siss_state_t d_d;
    siss_pins_t pins;
    siss_pins_t of;
    siss_pins_t nf;
    logic [7:0] in_st;
    logic [FRAME_W-1:0] load_word;
    logic [FRAME_W-1:0] push_word;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic sleep;
    logic push;
    wire logic [PINS_W-1:0] f_next;

    always_comb begin
        pins = '{cs_n: cs_n, sck: sck, mosi: mosi,
                 frame_length_select: frame_length_select,
                 bus_supply_sense: bus_supply_sense,
                 overtemp_alarm: overtemp_alarm,
                 bus_power_present: bus_power_present,
                 power_reset_n: power_reset_n,
                 input_state: input_state};
    end

    // per-pin level filter: stages two and three must agree
    for (genvar g = 0; g < PINS_W; g++) begin : g_filt
        assign f_next[g] = (q_q.s2[g] == q_q.s3[g]) ? q_q.s2[g] : q_q.f[g];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d_d = q_q;
        load_word = '0;
        push_word = '0;
        push = 1'b0;

        // three-stage sampling, level taken when stages two and three agree
        d_d.s1 = pins;
        d_d.s2 = q_q.s1;
        d_d.s3 = q_q.s2;
        d_d.f = f_next;
        of = siss_pins_t'(q_q.f);
        nf = siss_pins_t'(d_d.f);
        in_st = nf.input_state;
        cs_fall = of.cs_n & ~nf.cs_n;
        cs_rise = ~of.cs_n & nf.cs_n;
        sck_rise = ~of.sck & nf.sck;
        sck_fall = of.sck & ~nf.sck;
        sleep = ~nf.bus_power_present | ~nf.power_reset_n;

        // undervoltage filter
        if (nf.bus_supply_sense) begin
            d_d.uv_cnt = '0;
            d_d.uva_n = 1'b1;
        end else if (q_q.uv_cnt >= UV_LAST) begin
            d_d.uva_n = 1'b0;
        end else begin
            d_d.uv_cnt = q_q.uv_cnt + UV_CNT_W'(1);
        end

        // parallel load word
        load_word[15:8] = {in_st[7], in_st[6], in_st[5], in_st[4],
                           in_st[3], in_st[2], in_st[1], in_st[0]};
        load_word[POS_UVA] = d_d.uva_n;
        load_word[POS_OTA] = ~nf.overtemp_alarm;
        load_word[POS_PAR_FULL] = ~^in_st;
        load_word[POS_PAR_UPPER] = ~^in_st[7:4];
        load_word[POS_PAR_LOWER] = ~^in_st[3:0];
        load_word[POS_PAR_MIDDLE] = ~^in_st[5:2];
        load_word[POS_STOP_LOW] = STOP_LOW_VAL;
        load_word[POS_STOP_HIGH] = STOP_HIGH_VAL;
        if (nf.frame_length_select) begin
            load_word[7:0] = 8'h00;
        end

        // frame sequencing
        if (cs_fall) begin
            d_d.shift = load_word;
            d_d.long_mode = ~nf.frame_length_select;
            d_d.nbits = '0;
        end else if (~of.cs_n && ~nf.cs_n) begin
            if (sck_rise) begin
                d_d.mosi_cap = nf.mosi;
            end
            if (sck_fall) begin
                d_d.shift = {q_q.shift[FRAME_W-2:0], q_q.mosi_cap};
                if (q_q.nbits < LONG_BITS) begin
                    d_d.nbits = q_q.nbits + 5'h01;
                end
            end
        end
        // chip select high: clock and data are not looked at

        // finished frame: word received from the daisy chain input
        if (cs_rise) begin
            if (q_q.long_mode && q_q.nbits >= LONG_BITS) begin
                push = 1'b1;
                push_word = q_q.shift;
            end else if (~q_q.long_mode && q_q.nbits >= SHORT_BITS) begin
                push = 1'b1;
                push_word = {8'h00, q_q.shift[7:0]};
            end
            // shorter frames are dropped
        end

        // two-entry receive buffer
        if (rx_ready && q_q.v0) begin
            d_d.buf0 = q_q.buf1;
            d_d.v0 = q_q.v1;
            d_d.v1 = 1'b0;
        end
        if (push) begin
            if (!d_d.v0) begin
                d_d.buf0 = push_word;
                d_d.v0 = 1'b1;
            end else if (!d_d.v1) begin
                d_d.buf1 = push_word;
                d_d.v1 = 1'b1;
            end
        end

        // serial output
        d_d.miso_oe = ~nf.cs_n;
        d_d.miso = sleep ? 1'b0 : d_d.shift[FRAME_W-1];
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_q <= '0;
            q_q.s1 <= PIN_RST;
            q_q.s2 <= PIN_RST;
            q_q.s3 <= PIN_RST;
            q_q.f <= PIN_RST;
            q_q.uva_n <= 1'b1;
        end else begin
            q_q <= d_d;
        end
    end

    assign miso = q_q.miso;
    assign miso_oe = q_q.miso_oe;
    assign undervoltage_alarm_n = q_q.uva_n;
    assign rx_word = q_q.buf0;
    assign rx_valid = q_q.v0;
    assign rx_full = q_q.v1;

endmodule // siss_shifter

//--- test/siss_shifter_bench.sv
/* Self-checking bench for the input state shifter.
   Assumes siss_pkg, the master model and the bound checker. */
`timescale 1ns/10ps
module siss_shifter_bench;
    import siss_pkg::*;
    // ****************************************
    // stimulus and checks
    // ****************************************
    logic core_clk = 0, reset_n = 0, frame_length_select = 0, bus_supply_sense = 1;
    logic overtemp_alarm = 0, bus_power_present = 1, power_reset_n = 1, rx_ready = 1;
    logic [7:0] input_state = 8'h00;
    logic cs_n, sck, mosi, miso, miso_oe, undervoltage_alarm_n, rx_valid, rx_full, oe_ok;
    logic [FRAME_W-1:0] rx_word, got;
    logic [7:0] pats [5] = '{8'h00, 8'hff, 8'ha5, 8'h3c, 8'h81};
    int fail_count = 0, samples_checked = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    siss_spi_master i_master (.core_clk(core_clk), .miso(miso), .miso_oe(miso_oe),
        .cs_n(cs_n), .sck(sck), .mosi(mosi));
    siss_shifter #(.UV_FILT_CYCLES(20)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .cs_n(cs_n), .sck(sck), .mosi(mosi), .frame_length_select(frame_length_select),
        .bus_supply_sense(bus_supply_sense), .overtemp_alarm(overtemp_alarm),
        .bus_power_present(bus_power_present), .power_reset_n(power_reset_n),
        .input_state(input_state), .rx_ready(rx_ready), .miso(miso), .miso_oe(miso_oe),
        .undervoltage_alarm_n(undervoltage_alarm_n), .rx_word(rx_word),
        .rx_valid(rx_valid), .rx_full(rx_full));
    function automatic logic [15:0] exp_word(logic [7:0] d, logic uv_n, logic hot);
        return {d, uv_n, ~hot, ~^d, ~^d[7:4], ~^d[3:0], ~^d[5:2], 1'b0, 1'b1};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic lframe(input logic [15:0] tx, input logic [15:0] want);
        i_master.xfer(16, tx, got, oe_ok);
        check(got, want);
        check({15'h0, oe_ok}, 16'h0001);
        check({15'h0, miso_oe}, 16'h0000);
    endtask
    task automatic pop(input logic [15:0] want);
        check({15'h0, rx_valid}, 16'h0001);
        check(rx_word, want);
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        tick(1);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        tick(1);
        check({12'h0, miso_oe, rx_valid, rx_full, undervoltage_alarm_n}, 16'h0001);
        tick(1);
        reset_n = 1'b1;
        tick(6);
        foreach (pats[i]) begin
            input_state = pats[i];
            tick(6);
            lframe({pats[i], ~pats[i]}, exp_word(pats[i], 1, 0));
        end
        i_master.scan(got, oe_ok);
        check(got, exp_word(8'h81, 1, 0));
        overtemp_alarm = 1'b1;
        input_state = 8'h5a;
        tick(6);
        lframe(16'h0f0f, exp_word(8'h5a, 1, 1));
        overtemp_alarm = 1'b0;
        frame_length_select = 1'b1;
        rx_ready = 1'b0;
        tick(6);
        i_master.xfer(8, 16'h00c3, got, oe_ok);
        check(got, 16'h005a);
        pop(16'h00c3);
        rx_ready = 1'b1;
        frame_length_select = 1'b0;
        bus_supply_sense = 1'b0;
        tick(10);
        bus_supply_sense = 1'b1;
        tick(10);
        check({15'h0, undervoltage_alarm_n}, 16'h0001);
        bus_supply_sense = 1'b0;
        tick(40);
        check({15'h0, undervoltage_alarm_n}, 16'h0000);
        lframe(16'h1234, exp_word(8'h5a, 0, 0));
        bus_supply_sense = 1'b1;
        bus_power_present = 1'b0;
        tick(10);
        lframe(16'h4321, 16'h0000);
        bus_power_present = 1'b1;
        power_reset_n = 1'b0;
        tick(6);
        lframe(16'h8888, 16'h0000);
        power_reset_n = 1'b1;
        input_state = 8'h96;
        tick(6);
        i_master.xfer(5, 16'h0015, got, oe_ok);
        check(got, 16'h0012);
        rx_ready = 1'b0;
        lframe(16'ha1b2, exp_word(8'h96, 1, 0));
        lframe(16'hc3d4, exp_word(8'h96, 1, 0));
        lframe(16'he5f6, exp_word(8'h96, 1, 0));
        check({15'h0, rx_full}, 16'h0001);
        pop(16'ha1b2);
        pop(16'hc3d4);
        check({15'h0, rx_valid}, 16'h0000);
        close_out();
    end
endmodule // siss_shifter_bench

//--- test/siss_shifter_chk.sv
/* Pin checker for the input state shifter.
   Assumes binding onto siss_shifter ports. */
`timescale 1ns/10ps
module siss_shifter_chk #(
    parameter int UV_FILT_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic bus_supply_sense,
    input wire logic bus_power_present,
    input wire logic power_reset_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic undervoltage_alarm_n,
    input wire logic rx_valid,
    input wire logic rx_full
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ****************************************
    // pin checks
    // ****************************************
    int low_run_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_run_q <= 0;
        end else begin
            low_run_q <= bus_supply_sense ? 0 : low_run_q + 1;
        end
    end
    a_oe_release: assert property (cs_n [*7] |-> !miso_oe)
        else $error("output driven while deselected");
    a_oe_start: assert property ($fell(cs_n) |-> ##[2:8] miso_oe)
        else $error("no output after select");
    a_sleep_low: assert property ((!bus_power_present) [*7] ##0 miso_oe |-> !miso)
        else $error("output high in sleep");
    a_por_low: assert property ((!power_reset_n) [*7] ##0 miso_oe |-> !miso)
        else $error("output high in power reset");
    a_uv_filter: assert property ($fell(undervoltage_alarm_n) |-> low_run_q >= UV_FILT_CYCLES)
        else $error("alarm on short drop");
    a_uv_release: assert property (bus_supply_sense [*7] |-> undervoltage_alarm_n)
        else $error("alarm held with supply good");
    a_uv_raise: assert property (low_run_q == UV_FILT_CYCLES + 10 |-> !undervoltage_alarm_n)
        else $error("alarm missing on long drop");
    a_miso_hold: assert property (sck [*4] ##0 miso_oe |=> $stable(miso))
        else $error("output moved without clock fall");
    a_full_valid: assert property (rx_full |-> rx_valid)
        else $error("full without valid");
endmodule // siss_shifter_chk

bind siss_shifter siss_shifter_chk #(.UV_FILT_CYCLES(UV_FILT_CYCLES)) i_chk (
    .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
    .bus_supply_sense(bus_supply_sense), .bus_power_present(bus_power_present),
    .power_reset_n(power_reset_n), .miso(miso), .miso_oe(miso_oe),
    .undervoltage_alarm_n(undervoltage_alarm_n), .rx_valid(rx_valid), .rx_full(rx_full));

//--- test/siss_spi_master.sv
/* Mode 0 serial master model for the shifter.
   Assumes the bench calls xfer; pins move 1 ns after core_clk rise. */
`timescale 1ns/10ps
module siss_spi_master (
    input wire logic core_clk,
    input wire logic miso,
    input wire logic miso_oe,
    output logic cs_n,
    output logic sck,
    output logic mosi
);
    // ****************************************
    // frame driver
    // ****************************************
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx,
                        output logic oe);
        rx = '0;
        oe = 1'b1;
        cs_n = 1'b0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            mosi = tx[i];
            tick(4);
            // released line reads as the inverse of the last driven bit
            rx = {rx[14:0], miso_oe ? miso : ~miso};
            oe = oe & miso_oe;
            sck = 1'b1;
            tick(4);
            sck = 1'b0;
        end
        tick(6);
        cs_n = 1'b1;
        mosi = ~mosi;
        tick(8);
    endtask
    task automatic scan(output logic [15:0] word, output logic oe);
        xfer(16, 16'h0000, word, oe);
        if (word[5] !== ~^word[15:8]) begin
            xfer(16, 16'h0000, word, oe);
            xfer(16, 16'h0000, word, oe);
        end
    endtask
endmodule // siss_spi_master
